// ==== crf_pkg.sv ====
// package: register map, field layout and carriers of the core register file
`default_nettype none
package crf_pkg;
  localparam logic [6:0]  OFS_GPR0     = 7'h00; // r0..r13, ra, sp at 4*index
  localparam logic [6:0]  OFS_PSW      = 7'h40;
  localparam logic [6:0]  OFS_CFG      = 7'h44;
  localparam logic [6:0]  OFS_PC       = 7'h48;
  localparam logic [6:0]  OFS_ISP      = 7'h4c;
  localparam logic [6:0]  OFS_USP      = 7'h50;
  localparam logic [6:0]  OFS_DTB      = 7'h54;
  localparam logic [6:0]  OFS_STAT     = 7'h58;
  localparam logic [23:0] PC_RESET     = 24'h000000;
  localparam logic [15:0] PSW_RESET    = 16'h0200;
  localparam logic [15:0] PSW_WMASK    = 16'h0fef;
  localparam logic [15:0] CFG_WMASK    = 16'h0300;
  localparam int          SHORT_REGISTER_SELECT_BIT   = 9;
  localparam int          PSW_U_BIT    = 3;
  localparam logic [31:0] ISP_WMASK    = 32'h00fffffe;
  localparam logic [31:0] USP_LIMIT    = 32'h00ffffff;
  localparam logic [31:0] EXC_FRAME    = 32'h00000008;
  localparam logic [3:0]  WIDE_FIRST   = 4'hc;
  localparam logic [3:0]  NATIVE_LAST  = 4'hb;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    CRF_SZ_BYTE = 2'b00,
    CRF_SZ_WORD = 2'b01,
    CRF_SZ_PAIR = 2'b10
  } crf_size_e;

  typedef struct packed {
    logic      we;
    crf_size_e wsize;
    logic [3:0] widx;
    logic [31:0] wdata;
    crf_size_e rsize;
    logic [3:0] ridx;
  } crf_gpr_req_s;

  typedef struct packed {
    logic        entry;
    logic        ret;
    logic [23:0] ret_pc;
    logic [15:0] ret_psw;
  } crf_exc_req_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [23:0] pc;
    logic [15:0] psw;
  } crf_exc_save_s;
endpackage : crf_pkg
`default_nettype wire

// ==== crf_regfile.sv ====
// core register file with an AXI4-Lite window for software
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`default_nettype none
module crf_regfile
  import crf_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          warm_rst,
  input  wire crf_gpr_req_s  gpr_req,
  output logic [31:0]        gpr_rdata,
  input  wire logic          pc_load,
  input  wire logic [23:0]   pc_value,
  input  wire logic          psw_load,
  input  wire logic [15:0]   psw_value,
  input  wire crf_exc_req_s  exc_req,
  output crf_exc_save_s      exc_save,
  input  wire logic          stack_req,
  output logic [31:0]        stack_ptr,
  output logic               illegal_address_trap,
  output logic               short_register_select,
  output logic [23:0]        program_counter,
  output logic [31:0]        dispatch_table_base,
  input  wire logic [31:0]   s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [31:0]   s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready
);

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : strb_merge

  // low halves of all sixteen, upper halves only for r12..sp
  logic [15:0] gpr_lo_reg [16];
  logic [15:0] gpr_hi_reg [4];
  logic [15:0] psw_reg;
  logic [15:0] cfg_reg;
  logic [23:0] pc_reg;
  logic [31:0] isp_reg;
  logic [31:0] usp_reg;
  logic [31:0] dtb_reg;
  logic [7:0]  trap_cnt_reg;
  logic [31:0] rdata_reg;
  logic        trap_reg;
  crf_exc_save_s save_reg;

  logic        aw_held_reg;
  logic        w_held_reg;
  logic [6:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] axi_rdata_reg;

  wire logic sr_mode   = cfg_reg[SHORT_REGISTER_SELECT_BIT];
  wire logic user_mode = psw_reg[PSW_U_BIT];

  // full 32-bit view of every register: wide ones carry their upper half;
  // a process, not a function, so readers follow stores to any element
  logic [31:0] gpr_view [16];
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      gpr_view[i] = {16'h0000, gpr_lo_reg[i]};
      if (4'(i) >= WIDE_FIRST) gpr_view[i][31:16] = gpr_hi_reg[i[1:0]];
    end
  end

  // pair view depends on scheme; native r12..sp are single wide registers
  function automatic logic pair_splits(input logic [3:0] i, input logic sr);
    return (sr && i != 4'hf) || (!sr && i <= NATIVE_LAST);
  endfunction : pair_splits

  wire logic        rd_split  = pair_splits(gpr_req.ridx, sr_mode);
  wire logic [3:0]  rnext_idx = gpr_req.ridx + 4'h1;
  wire logic [31:0] rd_pair   = rd_split ? {gpr_lo_reg[rnext_idx], gpr_lo_reg[gpr_req.ridx]} :
                                           gpr_view[gpr_req.ridx];
  wire logic [31:0] rd_sel =
    (gpr_req.rsize == CRF_SZ_BYTE) ? {24'h000000, gpr_lo_reg[gpr_req.ridx][7:0]} :
    (gpr_req.rsize == CRF_SZ_WORD) ? {16'h0000, gpr_lo_reg[gpr_req.ridx]} :
    rd_pair;

  wire logic       pair_split = pair_splits(gpr_req.widx, sr_mode);
  wire logic [3:0] wnext_idx  = gpr_req.widx + 4'h1;
  wire logic       wide_w     = gpr_req.widx >= WIDE_FIRST;

  // stack selection and the user stack range check
  wire logic [31:0] sup_sp   = gpr_view[4'hf];
  wire logic [31:0] act_sp   = user_mode ? usp_reg : sup_sp;
  wire logic        usp_bad  = stack_req && user_mode && (usp_reg > USP_LIMIT);
  wire logic [31:0] isp_push = (isp_reg - EXC_FRAME) & ISP_WMASK;
  wire logic [31:0] isp_pop  = (isp_reg + EXC_FRAME) & ISP_WMASK;

  // AXI decode
  wire logic        axi_wr_go  = aw_held_reg && w_held_reg && !bvalid_reg;
  wire logic [4:0]  wr_word    = aw_addr_reg[6:2];
  wire logic        wr_gpr     = aw_addr_reg < OFS_PSW;
  wire logic        wr_hit     = aw_addr_reg <= OFS_DTB;
  wire logic [3:0]  wr_gidx    = wr_word[3:0];
  wire logic [31:0] wr_old     = wr_gpr ? gpr_view[wr_gidx] :
                                 (aw_addr_reg == OFS_PSW) ? {16'h0000, psw_reg} :
                                 (aw_addr_reg == OFS_CFG) ? {16'h0000, cfg_reg} :
                                 (aw_addr_reg == OFS_PC)  ? {8'h00, pc_reg} :
                                 (aw_addr_reg == OFS_ISP) ? isp_reg :
                                 (aw_addr_reg == OFS_USP) ? usp_reg : dtb_reg;
  wire logic [31:0] wr_val     = strb_merge(wr_old, w_data_reg, w_strb_reg);
  wire logic [6:0]  ar_ofs     = s_axi_araddr[6:0];
  wire logic        ar_hit     = (s_axi_araddr[31:7] == 25'h0) && (ar_ofs <= OFS_STAT);
  wire logic [31:0] ar_val     =
    (ar_ofs < OFS_PSW)   ? gpr_view[ar_ofs[5:2]] :
    (ar_ofs == OFS_PSW)  ? {16'h0000, psw_reg} :
    (ar_ofs == OFS_CFG)  ? {16'h0000, cfg_reg} :
    (ar_ofs == OFS_PC)   ? {8'h00, pc_reg} :
    (ar_ofs == OFS_ISP)  ? isp_reg :
    (ar_ofs == OFS_USP)  ? usp_reg :
    (ar_ofs == OFS_DTB)  ? dtb_reg :
    {22'h000000, sr_mode, user_mode, trap_cnt_reg};

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = axi_rdata_reg;
  assign gpr_rdata     = rdata_reg;
  assign stack_ptr     = act_sp;
  assign illegal_address_trap = trap_reg;
  assign short_register_select = sr_mode;
  assign program_counter = pc_reg;
  assign dispatch_table_base = dtb_reg;
  assign exc_save      = save_reg;

  // AXI channel bookkeeping; address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 7'h00;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= (s_axi_awaddr[31:7] == 25'h0) ? s_axi_awaddr[6:0] : 7'h7f;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (axi_wr_go) begin
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg    <= 1'b0;
      rresp_reg     <= RESP_OKAY;
      axi_rdata_reg <= 32'h00000000;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg    <= 1'b1;
      rresp_reg     <= ar_hit ? RESP_OKAY : RESP_SLVERR;
      axi_rdata_reg <= ar_hit ? ar_val : 32'h00000000;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg    <= 1'b0;
    end
  end

  // general registers: later assignments win, so core beats software
  // and warm reset beats both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 16; i++) gpr_lo_reg[i] <= 16'h0000;
      for (int i = 0; i < 4; i++) gpr_hi_reg[i] <= 16'h0000;
    end else begin
      if (axi_wr_go && wr_gpr) begin
        gpr_lo_reg[wr_gidx] <= wr_val[15:0];
        if (wr_gidx >= WIDE_FIRST) gpr_hi_reg[wr_gidx[1:0]] <= wr_val[31:16];
      end
      if (gpr_req.we) begin
        case (gpr_req.wsize)
          CRF_SZ_BYTE: gpr_lo_reg[gpr_req.widx][7:0] <= gpr_req.wdata[7:0];
          CRF_SZ_WORD: gpr_lo_reg[gpr_req.widx] <= gpr_req.wdata[15:0];
          CRF_SZ_PAIR: begin
            gpr_lo_reg[gpr_req.widx] <= gpr_req.wdata[15:0];
            if (pair_split) gpr_lo_reg[wnext_idx] <= gpr_req.wdata[31:16];
            else if (wide_w) gpr_hi_reg[gpr_req.widx[1:0]] <= gpr_req.wdata[31:16];
          end
          default: ;
        endcase
      end
      if (warm_rst) begin
        gpr_lo_reg[0] <= pc_reg[15:0];
        gpr_lo_reg[1] <= {8'h00, pc_reg[23:16]};
        gpr_lo_reg[2] <= psw_reg;
      end
    end
  end

  // dedicated registers, status and configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_reg  <= PC_RESET;
      psw_reg <= PSW_RESET;
      cfg_reg <= 16'h0000;
      isp_reg <= 32'h00000000;
      usp_reg <= 32'h00000000;
      dtb_reg <= 32'h00000000;
    end else begin
      if (axi_wr_go) begin
        case (aw_addr_reg)
          OFS_PSW: psw_reg <= wr_val[15:0] & PSW_WMASK;
          OFS_CFG: cfg_reg <= wr_val[15:0] & CFG_WMASK;
          OFS_PC:  pc_reg  <= {wr_val[23:1], 1'b0};
          OFS_ISP: isp_reg <= wr_val & ISP_WMASK;
          OFS_USP: usp_reg <= wr_val;
          OFS_DTB: dtb_reg <= wr_val;
          default: ;
        endcase
      end
      if (pc_load) pc_reg <= {pc_value[23:1], 1'b0};
      if (psw_load) psw_reg <= psw_value & PSW_WMASK;
      if (exc_req.entry) begin
        isp_reg <= isp_push;
        psw_reg[PSW_U_BIT] <= 1'b0;
      end else if (exc_req.ret) begin
        isp_reg <= isp_pop;
        pc_reg  <= {exc_req.ret_pc[23:1], 1'b0};
        psw_reg <= exc_req.ret_psw & PSW_WMASK;
      end
      if (warm_rst) begin
        pc_reg  <= PC_RESET;
        psw_reg <= PSW_RESET;
        cfg_reg <= 16'h0000;
      end
    end
  end

  // core read data, exception frame and trap outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_reg    <= 32'h00000000;
      trap_reg     <= 1'b0;
      trap_cnt_reg <= 8'h00;
      save_reg     <= '0;
    end else begin
      rdata_reg <= rd_sel;
      trap_reg  <= usp_bad;
      if (usp_bad) trap_cnt_reg <= trap_cnt_reg + 8'h01;
      save_reg.valid <= exc_req.entry;
      if (exc_req.entry) begin
        save_reg.addr <= isp_push;
        save_reg.pc   <= pc_reg;
        save_reg.psw  <= psw_reg;
      end
    end
  end

  AST_PC_EVEN: assert property (@(posedge aclk) disable iff (!aresetn)
    pc_reg[0] == 1'b0) else $error("program counter odd");
  AST_ISP_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
    (isp_reg & ~ISP_WMASK) == 32'h0) else $error("isp reserved bits set");
  AST_TRAP: assert property (@(posedge aclk) disable iff (!aresetn)
    stack_req && user_mode && usp_reg > USP_LIMIT |=> illegal_address_trap)
    else $error("user stack trap missed");
  AST_NO_TRAP: assert property (@(posedge aclk) disable iff (!aresetn)
    !stack_req || !user_mode |=> !illegal_address_trap)
    else $error("spurious trap");
  AST_WARM: assert property (@(posedge aclk) disable iff (!aresetn)
    warm_rst |=> gpr_lo_reg[0] == $past(pc_reg[15:0]) && pc_reg == PC_RESET)
    else $error("warm reset copy wrong");
  AST_WARM_HI: assert property (@(posedge aclk) disable iff (!aresetn)
    warm_rst |=> gpr_lo_reg[1] == {8'h00, $past(pc_reg[23:16])})
    else $error("warm reset upper copy wrong");
  AST_CFG_RST: assert property (@(posedge aclk)
    !aresetn |=> cfg_reg == 16'h0000) else $error("config not cleared");
  AST_CFG_WARM: assert property (@(posedge aclk) disable iff (!aresetn)
    warm_rst |=> !short_register_select) else $error("config kept over warm reset");
  AST_PUSH: assert property (@(posedge aclk) disable iff (!aresetn)
    exc_req.entry && !warm_rst |=> exc_save.valid && isp_reg == exc_save.addr)
    else $error("exception push wrong");
  AST_POP: assert property (@(posedge aclk) disable iff (!aresetn)
    exc_req.ret && !exc_req.entry && !warm_rst
    |=> isp_reg == (($past(isp_reg) + EXC_FRAME) & ISP_WMASK))
    else $error("exception pop wrong");
  AST_USER_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
    exc_req.entry && !warm_rst |=> !user_mode) else $error("exception left user mode");
  AST_PC_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    pc_load && !exc_req.ret && !warm_rst |=> pc_reg == {$past(pc_value[23:1]), 1'b0})
    else $error("program counter load wrong");
  AST_BYTE: assert property (@(posedge aclk) disable iff (!aresetn)
    gpr_req.we && gpr_req.wsize == CRF_SZ_BYTE && !warm_rst && !axi_wr_go
    |=> gpr_lo_reg[$past(gpr_req.widx)][15:8] == $past(gpr_lo_reg[gpr_req.widx][15:8]))
    else $error("byte write touched upper byte");
  AST_SR_PAIR: assert property (@(posedge aclk) disable iff (!aresetn)
    gpr_req.rsize == CRF_SZ_PAIR && sr_mode && gpr_req.ridx != 4'hf
    |=> gpr_rdata == {$past(gpr_lo_reg[rnext_idx]), $past(gpr_lo_reg[gpr_req.ridx])})
    else $error("short pair read wrong");
  AST_WIDE_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    gpr_req.rsize == CRF_SZ_PAIR && !sr_mode && gpr_req.ridx >= WIDE_FIRST
    |=> gpr_rdata == {$past(gpr_hi_reg[gpr_req.ridx[1:0]]), $past(gpr_lo_reg[gpr_req.ridx])})
    else $error("wide register read wrong");
  AST_DTB_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
    axi_wr_go && aw_addr_reg == OFS_DTB && w_strb_reg == 4'hf
    |=> dispatch_table_base == $past(w_data_reg)) else $error("dispatch base altered");
  AST_RVALID: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_BRESP: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");

endmodule : crf_regfile
`default_nettype wire

// ==== crf_regfile_tb.sv ====
// self-checking bench of the core register file
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module crf_regfile_tb
  import crf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          aclk, aresetn, warm_rst, pc_load, psw_load, stack_req, trap, srs;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic          s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0]    s_axi_wstrb;
  logic [15:0]   psw_value, lfsr_q;
  logic [23:0]   pc_value, pc_out;
  logic [31:0]   s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [31:0]   gpr_rdata, stack_ptr, dtb, rd, d, v;
  logic [31:0]   gm [16];
  crf_gpr_req_s  gpr_req;
  crf_exc_req_s  exc_req;
  crf_exc_save_s exc_save;
  int            fails, checked;

  crf_regfile dut (
    .aclk(aclk), .aresetn(aresetn), .warm_rst(warm_rst), .gpr_req(gpr_req),
    .gpr_rdata(gpr_rdata), .pc_load(pc_load), .pc_value(pc_value), .psw_load(psw_load),
    .psw_value(psw_value), .exc_req(exc_req), .exc_save(exc_save), .stack_req(stack_req),
    .stack_ptr(stack_ptr), .illegal_address_trap(trap), .short_register_select(srs),
    .program_counter(pc_out), .dispatch_table_base(dtb),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  always #25 aclk = ~aclk;

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step

  task automatic rnd(output logic [31:0] r);
    lfsr_q = lfsr_step(lfsr_q);
    r[31:16] = lfsr_q;
    lfsr_q = lfsr_step(lfsr_q);
    r[15:0] = lfsr_q;
  endtask : rnd

  // wide registers read whole in native mode, the stack pointer always
  function automatic logic [31:0] pair_exp(input int i, input logic sr);
    if ((!sr && i >= 12) || i == 15) return gm[i];
    return {gm[i+1][15:0], gm[i][15:0]};
  endfunction : pair_exp

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input int s);
    if (s == 0) return {o[31:8], n[7:0]};
    if (s == 1) return {o[31:16], n[15:0]};
    return n;
  endfunction : merge

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] dat, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // idle edge: the next call must not raise bready in this same step
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] dat, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    dat = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  task automatic gwr(input int i, input int s, input logic [31:0] dat);
    gpr_req.we <= 1'b1;
    gpr_req.widx <= i[3:0];
    gpr_req.wsize <= crf_size_e'(s[1:0]);
    gpr_req.wdata <= dat;
    @(posedge aclk);
    gpr_req.we <= 1'b0;
    @(posedge aclk);
  endtask : gwr

  task automatic grd(input int i, input crf_size_e s, output logic [31:0] r);
    gpr_req.ridx <= i[3:0];
    gpr_req.rsize <= s;
    repeat (2) @(posedge aclk);
    r = gpr_rdata;
  endtask : grd

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    stop_test();
  end

  initial begin
    {aclk, aresetn, warm_rst, pc_load, psw_load, stack_req} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, pc_value, psw_value} = '0;
    s_axi_wstrb = 4'hf;
    gpr_req = '0;
    exc_req = '0;
    lfsr_q = 16'h846a;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(32'(OFS_PSW), rd, rsp);
    `CHK(rd[11:0], PSW_RESET[11:0])
    axi_rd(32'(OFS_CFG), rd, rsp);
    `CHK({srs, rd[9:8]}, 3'h0)
    axi_rd(32'(OFS_PC), rd, rsp);
    `CHK(rd[23:0], PC_RESET)
    for (int i = 0; i < 16; i++) begin
      rnd(d);
      gm[i] = (i < 12) ? {16'h0, d[15:0]} : d;
      axi_wr(32'(4 * i), gm[i], rsp);
    end
    for (int i = 0; i < 16; i++) begin
      axi_rd(32'(4 * i), rd, rsp);
      if (i < 12) `CHK(rd[15:0], gm[i][15:0])
      else `CHK(rd, gm[i])
    end
    // upper lanes only: the low half of a wide register must survive
    rnd(d);
    s_axi_wstrb <= 4'hc;
    axi_wr(32'(4 * 13), d, rsp);
    s_axi_wstrb <= 4'hf;
    gm[13] = {d[31:16], gm[13][15:0]};
    axi_rd(32'(4 * 13), rd, rsp);
    `CHK(rd, gm[13])
    for (int s = 0; s < 3; s++) begin
      rnd(d);
      gwr(12, s, d);
      gm[12] = merge(gm[12], d, s);
      grd(12, CRF_SZ_PAIR, rd);
      `CHK(rd, gm[12])
    end
    grd(3, CRF_SZ_WORD, rd);
    `CHK(rd[15:0], gm[3][15:0])
    foreach (gm[i]) begin
      grd(i, CRF_SZ_PAIR, rd);
      `CHK(rd, pair_exp(i, 1'b0))
    end
    axi_wr(32'(OFS_CFG), 32'h00000200, rsp);
    `CHK(srs, 1'b1)
    for (int i = 9; i < 16; i++) begin
      grd(i, CRF_SZ_PAIR, rd);
      if (i != 14) `CHK(rd, pair_exp(i, 1'b1))
    end
    axi_wr(32'(OFS_CFG), 32'h0, rsp);
    rnd(d);
    d = d & 32'h00fffffe;
    axi_wr(32'(OFS_DTB), d, rsp);
    axi_rd(32'(OFS_DTB), rd, rsp);
    `CHK({rd, dtb}, {d, d})
    rnd(v);
    pc_value <= v[23:0] | 24'h1;
    pc_load <= 1'b1;
    @(posedge aclk);
    pc_load <= 1'b0;
    @(posedge aclk);
    v[0] = 1'b0;
    `CHK(pc_out, v[23:0])
    psw_value <= 16'h0208;
    psw_load <= 1'b1;
    @(posedge aclk);
    psw_load <= 1'b0;
    // boundary address must pass, one above it must trap
    for (int k = 0; k < 2; k++) begin
      d = (k == 0) ? USP_LIMIT : USP_LIMIT + 32'h1;
      axi_wr(32'(OFS_USP), d, rsp);
      `CHK(stack_ptr, d)
      stack_req <= 1'b1;
      @(posedge aclk);
      stack_req <= 1'b0;
      @(posedge aclk);
      `CHK(trap, k[0])
    end
    axi_wr(32'(OFS_ISP), 32'hffffffff, rsp);
    axi_rd(32'(OFS_ISP), rd, rsp);
    `CHK(rd, 32'h00fffffe)
    exc_req.entry <= 1'b1;
    @(posedge aclk);
    exc_req.entry <= 1'b0;
    @(posedge aclk);
    `CHK({exc_save.valid, exc_save.addr, exc_save.pc}, {1'b1, 32'h00fffff6, v[23:0]})
    `CHK(stack_ptr, gm[15])
    rnd(d);
    exc_req.ret_pc <= d[23:0] & 24'hfffffe;
    exc_req.ret_psw <= PSW_RESET;
    exc_req.ret <= 1'b1;
    @(posedge aclk);
    exc_req.ret <= 1'b0;
    @(posedge aclk);
    `CHK(pc_out, d[23:0] & 24'hfffffe)
    axi_rd(32'(OFS_ISP), rd, rsp);
    `CHK(rd, 32'h00fffffe)
    psw_value <= 16'h0205;
    psw_load <= 1'b1;
    warm_rst <= 1'b0;
    @(posedge aclk);
    psw_load <= 1'b0;
    warm_rst <= 1'b1;
    @(posedge aclk);
    warm_rst <= 1'b0;
    @(posedge aclk);
    `CHK(pc_out, PC_RESET)
    grd(0, CRF_SZ_PAIR, rd);
    `CHK(rd, {8'h00, d[23:1], 1'b0})
    axi_wr(32'(OFS_STAT), 32'h1, rsp);
    `CHK(rsp, RESP_SLVERR)
    axi_rd(32'h0000005c, rd, rsp);
    `CHK(rsp, RESP_SLVERR)
    stop_test();
  end
endmodule : crf_regfile_tb
`default_nettype wire
